// file: rtl/laser_status_flags.sv
// Fatal and warning status registers plus read-only capability words of a tunable laser.
// Assumes the serial decoder presents one-cycle read/write strobes and that the line,
// fault and event inputs come from logic on the same clock; only the disable pin is async.
`timescale 1ns/10ps

// Contract
// - Two status words at 0x20 and 0x21
// - Upper byte live, writes ignored silently
// - Lower byte held, 0x00FF write clears
// - Bit 15 shows service request line
// - Bit 14 shows alarm line
// - Bit 13 shows fatal line
// - Bit 12 high while disable pin low
// - Disable pin clears software enable
// - Disable change may raise service request
// - Bit 11 vendor fault, per register
// - Bit 10 frequency deviation, per register
// - Bits 3:0 latch bits 11:8
// - Event bits 7:4 held only
// - Bit 9 thermal deviation, per register
// - Bit 8 power deviation, per register
// - Restart bit set on any restart
// - Writing one clears that held bit
module laser_status_flags (
   input wire logic clk,
   input wire logic nrst,
   input wire laser_status_pkg::reg_req_t regReq,
   output logic [15:0] regRdata,
   output logic regAck,
   input wire logic srqLineN,
   input wire logic almLineN,
   input wire logic fatalLineN,
   input wire logic outputOffPinN,
   input wire logic srqDisMask,
   input wire laser_status_pkg::fault_t fatalNow,
   input wire laser_status_pkg::fault_t warnNow,
   input wire laser_status_pkg::event_t events,
   input wire logic swEnableSet,
   output logic swOutputEnable,
   output logic offChangeReq
);

   // ************************************************************
   // Disable pin synchroniser
   // ************************************************************
   logic offPinLevel; // Filtered pin, high means output allowed
   logic offPinPrev_ff; // Last filtered value for change detect
   logic disFlag; // High while output is hardware disabled

   pin_sync #(.RESET_LEVEL(1'b1)) u_off_sync (
      .clk(clk),
      .nrst(nrst),
      .pinIn(outputOffPinN),
      .pinOut(offPinLevel)
   );

   assign disFlag = ~offPinLevel;

   // Remember the previous pin level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         offPinPrev_ff <= 1'b1;
      end else begin
         offPinPrev_ff <= offPinLevel;
      end
   end

   // Change pulse toward the service request logic, gated by its mask bit
   assign offChangeReq = (offPinLevel != offPinPrev_ff) && srqDisMask;

   // ************************************************************
   // Software output enable
   // ************************************************************
   // Pin low wins over a set; output stays off after release until set again
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         swOutputEnable <= 1'b0;
      end else if (disFlag) begin
         swOutputEnable <= 1'b0;
      end else if (swEnableSet) begin
         swOutputEnable <= 1'b1;
      end
   end

   // ************************************************************
   // Live upper bytes
   // ************************************************************
   logic [3:0] lineBits; // Shared srq/alm/fatal/dis flags
   logic [7:0] fatalLive; // Upper byte of fatal word
   logic [7:0] warnLive; // Upper byte of warning word

   // Active-low lines read as one while asserted
   assign lineBits = {~srqLineN, ~almLineN, ~fatalLineN, disFlag};
   assign fatalLive = {lineBits, fatalNow};
   assign warnLive = {lineBits, warnNow};

   // ************************************************************
   // Held lower bytes
   // ************************************************************
   logic [7:0] fatalHeld_ff; // Lower byte of fatal word
   logic [7:0] warnHeld_ff; // Lower byte of warning word
   logic [7:0] nxt_fatalHeld; // Next fatal held byte
   logic [7:0] nxt_warnHeld; // Next warning held byte
   logic [3:0] eventBits; // Event sources for bits 7:4

   assign eventBits = events;

   // Write-one-to-clear mask for one status address; only the low byte counts
   function automatic logic [7:0] clr_mask(input laser_status_pkg::reg_req_t req, input logic [7:0] addr);
      clr_mask = (req.wr && req.addr == addr) ? req.wdata[7:0] : 8'h00;
   endfunction

   // Set terms are ORed after the clear so an event in the clear cycle survives
   always_comb begin
      nxt_fatalHeld = (fatalHeld_ff & ~clr_mask(regReq, laser_status_pkg::ADDR_FATAL_STATUS))
                      | {eventBits, fatalNow};
      nxt_warnHeld = (warnHeld_ff & ~clr_mask(regReq, laser_status_pkg::ADDR_WARNING_STATUS))
                     | {eventBits, warnNow};
   end

   // Restart and link reset come up set by definition
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fatalHeld_ff <= laser_status_pkg::HELD_RESET;
         warnHeld_ff <= laser_status_pkg::HELD_RESET;
      end else begin
         fatalHeld_ff <= nxt_fatalHeld;
         warnHeld_ff <= nxt_warnHeld;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   logic [15:0] nxt_rdata; // Selected read word
   logic [15:0] rdata_ff; // Registered read data
   logic ack_ff; // Answer strobe

   // Decode the address; writes to live bits and constants change nothing
   always_comb begin
      unique case (regReq.addr)
         laser_status_pkg::ADDR_FATAL_STATUS: nxt_rdata = {fatalLive, fatalHeld_ff};
         laser_status_pkg::ADDR_WARNING_STATUS: nxt_rdata = {warnLive, warnHeld_ff};
         laser_status_pkg::ADDR_LAST_FREQ_THZ: nxt_rdata = laser_status_pkg::LAST_FREQ_THZ_VAL;
         laser_status_pkg::ADDR_LAST_FREQ_GHZ: nxt_rdata = laser_status_pkg::LAST_FREQ_GHZ_VAL;
         laser_status_pkg::ADDR_MIN_GRID: nxt_rdata = laser_status_pkg::MIN_GRID_VAL;
         default: nxt_rdata = laser_status_pkg::UNMAPPED_VAL;
      endcase
   end

   // Every strobe is answered one cycle later; data held until next read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= 16'h0000;
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= regReq.rd | regReq.wr;
         if (regReq.rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign regRdata = rdata_ff;
   assign regAck = ack_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   chk_fatal_read_map: assert property (regReq.rd && regReq.addr == laser_status_pkg::ADDR_FATAL_STATUS
      |=> regRdata == {$past(fatalLive), $past(fatalHeld_ff)})
      else $error("Fatal status read wrong");
   chk_live_write_ignored: assert property (regReq.wr && regReq.wdata == 16'hFF00
      |=> fatalHeld_ff[3:0] == ($past(fatalHeld_ff[3:0]) | $past(fatalNow)))
      else $error("High byte write changed held bits");
   chk_clear_all_held: assert property (regReq.wr && regReq.addr == laser_status_pkg::ADDR_WARNING_STATUS
      && regReq.wdata[7:0] == 8'hFF && events == 4'h0 && warnNow == 4'h0 |=> warnHeld_ff == 8'h00)
      else $error("Warning held byte not cleared");
   chk_srq_bit: assert property (regReq.rd && regReq.addr == laser_status_pkg::ADDR_WARNING_STATUS
      |=> regRdata[15:13] == ~$past({srqLineN, almLineN, fatalLineN}))
      else $error("Line flags do not mirror lines");
   chk_dis_clears_en: assert property (disFlag |=> !swOutputEnable)
      else $error("Enable survived hardware disable");
   chk_en_stays_off: assert property (!swOutputEnable && !swEnableSet |=> !swOutputEnable)
      else $error("Enable rose without software set");
   chk_dis_change: assert property ($changed(offPinLevel) && srqDisMask |-> offChangeReq)
      else $error("Disable change not reported");
   // Either word's frequency fault must be held on the next edge, whatever the host writes
   chk_fault_latches: assert property (fatalNow.freq || warnNow.freq
      |=> (fatalHeld_ff[2] || !$past(fatalNow.freq)) && (warnHeld_ff[2] || !$past(warnNow.freq)))
      else $error("Frequency fault not latched");
   chk_set_beats_clear: assert property (events.restart |=> fatalHeld_ff[5] && warnHeld_ff[5])
      else $error("Restart event lost");
   chk_held_sticks: assert property (fatalHeld_ff[7] && !(regReq.wr && regReq.addr ==
      laser_status_pkg::ADDR_FATAL_STATUS && regReq.wdata[7]) |=> fatalHeld_ff[7])
      else $error("Held bit dropped without clear");
   chk_grid_const: assert property (regReq.rd && regReq.addr == laser_status_pkg::ADDR_MIN_GRID
      |=> regRdata == laser_status_pkg::MIN_GRID_VAL && regAck)
      else $error("Grid constant wrong");
   // Mask bit low must keep pin changes away from the service request logic
   chk_mask_blocks: assert property (!srqDisMask |-> !offChangeReq)
      else $error("Change request while masked");
   chk_ack_follows: assert property (regReq.rd || regReq.wr |=> regAck)
      else $error("Strobe not acknowledged");

   cov_clear_fatal: cover property (regReq.wr && regReq.addr == laser_status_pkg::ADDR_FATAL_STATUS
      && regReq.wdata[7:0] == 8'hFF);
   cov_pin_disable: cover property (offPinLevel ##1 !offPinLevel);
   cov_set_clear_race: cover property (events.runFault && regReq.wr && regReq.wdata[7]);
   cov_reenable: cover property (!swOutputEnable ##1 swOutputEnable);

endmodule

// file: shared/laser_status_pkg.sv
// Register map, field layout, reset values and carrier types of the laser status block.
// Assumes one 100 MHz clock and a register port driven by the serial command decoder.
package laser_status_pkg;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [7:0] ADDR_FATAL_STATUS = 8'h20; // Fatal status word
   localparam logic [7:0] ADDR_WARNING_STATUS = 8'h21; // Warning status word
   localparam logic [7:0] ADDR_LAST_FREQ_THZ = 8'h54; // Last frequency, THz part
   localparam logic [7:0] ADDR_LAST_FREQ_GHZ = 8'h55; // Last frequency, GHz part
   localparam logic [7:0] ADDR_MIN_GRID = 8'h56; // Minimum grid spacing

   // ************************************************************
   // Field positions inside a status word
   // ************************************************************
   localparam int BIT_SRQ = 15; // Service request line flag
   localparam int BIT_ALM = 14; // Alarm line flag
   localparam int BIT_FATAL = 13; // Fatal line flag
   localparam int BIT_DIS = 12; // Hardware output-off flag
   localparam int LIVE_FAULT_LSB = 8; // Live vendor/freq/thermal/power at 11:8
   localparam int BIT_RUN_FAULT = 7; // Execution error, held
   localparam int BIT_LINK_FAULT = 6; // Communication error, held
   localparam int BIT_RESTART = 5; // Module restart, held
   localparam int BIT_LINK_RESET = 4; // Communication reset, held

   // ************************************************************
   // Reset values and constants
   // ************************************************************
   localparam logic [7:0] HELD_RESET = 8'h30; // Restart and link reset set by definition
   localparam logic [15:0] LAST_FREQ_THZ_VAL = 16'h00C4; // Plain default, product specific
   localparam logic [15:0] LAST_FREQ_GHZ_VAL = 16'h0000; // Plain default, product specific
   localparam logic [15:0] MIN_GRID_VAL = 16'h0019; // Plain default, product specific
   localparam logic [15:0] UNMAPPED_VAL = 16'h0000; // Answer for unknown address

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic vendor; // Vendor specific fault
      logic freq; // Frequency deviation over limit
      logic thermal; // Thermal deviation over limit
      logic power; // Power deviation over limit
   } fault_t;

   typedef struct packed {
      logic runFault; // Execution error pulse
      logic linkFault; // Communication error pulse
      logic restart; // Firmware restart or software reset pulse
      logic linkReset; // Communication reset pulse
   } event_t;

   typedef struct packed {
      logic rd; // Read strobe
      logic wr; // Write strobe
      logic [7:0] addr; // Register number
      logic [15:0] wdata; // Write data
   } reg_req_t;

endpackage

// file: rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes the pin is quiet long enough to be sampled on two successive edges.
`timescale 1ns/10ps
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic pinIn,
   output logic pinOut
);

   // ************************************************************
   // Synchroniser chain
   // ************************************************************
   logic s1_ff; // First stage, read only by second
   logic s2_ff; // Second stage
   logic s3_ff; // Third stage
   logic level_ff; // Filtered level

   // Shift the pin through three flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_ff <= RESET_LEVEL;
         s2_ff <= RESET_LEVEL;
         s3_ff <= RESET_LEVEL;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Accept a change only once two stages agree, so one metastable sample cannot pass
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         level_ff <= RESET_LEVEL;
      end else if (s2_ff == s3_ff) begin
         level_ff <= s3_ff;
      end
   end

   assign pinOut = level_ff;

endmodule

// file: tb/status_host.sv
// Host model that issues register reads and writes to the status block.
// Assumes strobes are taken on a rising edge and acknowledged one cycle later.
`timescale 1ns/10ps
module status_host (
   input wire logic clk,
   input wire logic regAck,
   input wire logic [15:0] regRdata,
   output laser_status_pkg::reg_req_t regReq,
   output logic timedOut
);
   // ************************************************************
   // Request driver
   // ************************************************************
   // Idle port at time zero
   initial begin
      regReq = '0;
      timedOut = 1'b0;
   end

   // One strobe, then a bounded wait for the acknowledge
   task automatic issue(input logic wr, input logic [7:0] addr, input logic [15:0] wdata);
      int n;
      n = 0;
      @(posedge clk);
      #1 regReq = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
      @(posedge clk);
      #1 regReq.rd = 1'b0;
      regReq.wr = 1'b0;
      while (regAck !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1 n++;
      end
      // Missing acknowledge is flagged, never waited out
      if (n == 4) begin
         timedOut = 1'b1;
      end
   endtask

   // Read data is taken once the acknowledge is seen
   task automatic doRead(input logic [7:0] addr, output logic [15:0] data);
      issue(1'b0, addr, 16'h0000);
      data = regRdata;
   endtask

   // Clears are plain writes of ones to the held positions
   task automatic doWrite(input logic [7:0] addr, input logic [15:0] wdata);
      issue(1'b1, addr, wdata);
   endtask
endmodule

// file: tb/laser_status_flags_bench.sv
// Self-checking bench for the laser status block.
// Assumes the host model in status_host.sv drives the register port.
`timescale 1ns/10ps
module laser_status_flags_bench;
   logic clk;
   logic nrst;
   laser_status_pkg::reg_req_t regReq;
   logic [15:0] regRdata;
   logic regAck;
   logic srqLineN;
   logic almLineN;
   logic fatalLineN;
   logic outputOffPinN;
   logic srqDisMask;
   laser_status_pkg::fault_t fatalNow;
   laser_status_pkg::fault_t warnNow;
   laser_status_pkg::event_t events;
   logic swEnableSet;
   logic swOutputEnable;
   logic offChangeReq;
   logic timedOut;
   logic [15:0] rd;
   logic seen;
   int err_total = 0;
   int tests_run = 0;
   logic [7:0] capAddr [3] = '{laser_status_pkg::ADDR_LAST_FREQ_THZ, laser_status_pkg::ADDR_LAST_FREQ_GHZ,
      laser_status_pkg::ADDR_MIN_GRID};
   logic [15:0] capVal [3] = '{laser_status_pkg::LAST_FREQ_THZ_VAL, laser_status_pkg::LAST_FREQ_GHZ_VAL,
      laser_status_pkg::MIN_GRID_VAL};

   laser_status_flags dut_u (.clk(clk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata), .regAck(regAck),
      .srqLineN(srqLineN), .almLineN(almLineN), .fatalLineN(fatalLineN), .outputOffPinN(outputOffPinN),
      .srqDisMask(srqDisMask), .fatalNow(fatalNow), .warnNow(warnNow), .events(events),
      .swEnableSet(swEnableSet), .swOutputEnable(swOutputEnable), .offChangeReq(offChangeReq));
   status_host host_u (.clk(clk), .regAck(regAck), .regRdata(regRdata), .regReq(regReq), .timedOut(timedOut));

   // ************************************************************
   // Helpers
   // ************************************************************
   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // One compare, mismatches reported at once
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Both held bytes cleared so each test starts clean
   task automatic clearBoth();
      host_u.doWrite(laser_status_pkg::ADDR_FATAL_STATUS, 16'h00FF);
      host_u.doWrite(laser_status_pkg::ADDR_WARNING_STATUS, 16'h00FF);
   endtask

   // Bounded watch for the disable-change request pulse
   task automatic waitChange(output logic hit);
      hit = 1'b0;
      repeat (12) begin
         @(posedge clk);
         #1 hit = hit | (offChangeReq === 1'b1);
      end
   endtask

   // Single exit point for the verdict
   task automatic close_out();
      chk({15'h0, timedOut}, 16'h0000, "ack timeout");
      $display("Compares %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {srqLineN, almLineN, fatalLineN, outputOffPinN} = 4'hF;
      {srqDisMask, swEnableSet} = 2'b10;
      {fatalNow, warnNow, events} = '0;
      nrst = 1'b0;
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      // Live lines low, upper-byte write must not disturb anything
      {srqLineN, almLineN, fatalLineN} = 3'b000;
      host_u.doWrite(laser_status_pkg::ADDR_FATAL_STATUS, 16'hFF00);
      host_u.doRead(laser_status_pkg::ADDR_FATAL_STATUS, rd);
      chk(rd, 16'hE030, "fatal word after reset");
      host_u.doRead(laser_status_pkg::ADDR_WARNING_STATUS, rd);
      chk(rd, 16'hE030, "warning word after reset");
      {srqLineN, almLineN, fatalLineN} = 3'b111;
      $display("Test lines done");
      // Separate live faults per word, then held copies and single-bit clears
      clearBoth();
      fatalNow = 4'hA;
      warnNow = 4'h5;
      repeat (3) @(posedge clk);
      host_u.doRead(laser_status_pkg::ADDR_FATAL_STATUS, rd);
      chk(rd, 16'h0A0A, "fatal faults");
      host_u.doRead(laser_status_pkg::ADDR_WARNING_STATUS, rd);
      chk(rd, 16'h0505, "warning faults");
      {fatalNow, warnNow} = '0;
      host_u.doWrite(laser_status_pkg::ADDR_FATAL_STATUS, 16'h0002);
      host_u.doRead(laser_status_pkg::ADDR_FATAL_STATUS, rd);
      chk(rd, 16'h0008, "single clear");
      host_u.doRead(laser_status_pkg::ADDR_WARNING_STATUS, rd);
      chk(rd, 16'h0005, "other word kept");
      // Clear while frequency and power faults are active keeps their bits
      fatalNow = 4'h5;
      host_u.doWrite(laser_status_pkg::ADDR_FATAL_STATUS, 16'h00FF);
      host_u.doRead(laser_status_pkg::ADDR_FATAL_STATUS, rd);
      chk(rd, 16'h0505, "set beats clear");
      fatalNow = 4'h0;
      $display("Test faults done");
      // Every event reaches its held bit in both words
      for (int i = 0; i < 4; i++) begin
         clearBoth();
         @(posedge clk);
         #1 events = 4'(1 << i);
         @(posedge clk);
         #1 events = 4'h0;
         host_u.doRead(laser_status_pkg::ADDR_FATAL_STATUS, rd);
         chk(rd, 16'(1 << (4 + i)), "event fatal word");
         host_u.doRead(laser_status_pkg::ADDR_WARNING_STATUS, rd);
         chk(rd, 16'(1 << (4 + i)), "event warning word");
      end
      clearBoth();
      $display("Test events done");
      // Hardware disable pin against the software enable
      @(posedge clk);
      #1 swEnableSet = 1'b1;
      @(posedge clk);
      #1 swEnableSet = 1'b0;
      chk({15'h0, swOutputEnable}, 16'h0001, "enable set");
      outputOffPinN = 1'b0;
      waitChange(seen);
      chk({15'h0, seen}, 16'h0001, "change request on fall");
      chk({15'h0, swOutputEnable}, 16'h0000, "enable dropped");
      host_u.doRead(laser_status_pkg::ADDR_FATAL_STATUS, rd);
      chk(rd, 16'h1000, "disable flag");
      @(posedge clk);
      #1 swEnableSet = 1'b1;
      @(posedge clk);
      #1 swEnableSet = 1'b0;
      outputOffPinN = 1'b1;
      waitChange(seen);
      chk({15'h0, seen}, 16'h0001, "change request on rise");
      chk({15'h0, swOutputEnable}, 16'h0000, "stays off");
      host_u.doRead(laser_status_pkg::ADDR_WARNING_STATUS, rd);
      chk(rd, 16'h0000, "disable flag gone");
      // Software set after release brings the output back
      @(posedge clk);
      #1 swEnableSet = 1'b1;
      @(posedge clk);
      #1 swEnableSet = 1'b0;
      chk({15'h0, swOutputEnable}, 16'h0001, "re-enabled");
      // Mask bit low hides both pin edges
      srqDisMask = 1'b0;
      outputOffPinN = 1'b0;
      waitChange(seen);
      chk({15'h0, seen}, 16'h0000, "masked fall");
      outputOffPinN = 1'b1;
      waitChange(seen);
      chk({15'h0, seen}, 16'h0000, "masked rise");
      srqDisMask = 1'b1;
      $display("Test pin done");
      // Capability words ignore writes, unmapped reads as zero
      for (int i = 0; i < 3; i++) begin
         host_u.doWrite(capAddr[i], 16'hFFFF);
         host_u.doRead(capAddr[i], rd);
         chk(rd, capVal[i], "capability word");
      end
      host_u.doRead(8'h00, rd);
      chk(rd, laser_status_pkg::UNMAPPED_VAL, "unmapped read");
      $display("Test capability done");
      close_out();
   end
endmodule
